// ===== verilog/ebsi_indicator.sv
// status, alarm and link lamp logic of the network board, with a small register port
// assumes all inputs synchronous to clk; strobes are one cycle wide
// What this block does
// - show processor, firmware, handoff start patterns
// - step four operating-system phase patterns
// - completion: lamp one blinks, others dark
// - hold completion until an error arrives
// - on error alternate LONG then SHORT forever
// - LONG interval clearly longer than SHORT
// - three distinct codes for local faults
// - fourth code for another module's nmi
// - alarm lamp lights on memory parity error
// - activity lamp lights on receive or transmit while the link lamp is lit
// - link lamp follows hub connection
// - collision lamp lights on collision
// - fast lamp lights on 100BASE-TX link
// - no frames while link lamp dark
`timescale 1ns/1ps
module ebsi_indicator #(
	parameter int         TICK_CYCLES = ebsi_pkg::TICK_CYCLES,  // cycles per 1 ms tick
	parameter logic [3:0] LONG_PAT    = ebsi_pkg::ERR_LONG_PAT, // LONG lamps, all codes
	parameter logic [3:0] SHORT_PAT0  = ebsi_pkg::ERR_SHORT0,   // SHORT lamps, parity
	parameter logic [3:0] SHORT_PAT1  = ebsi_pkg::ERR_SHORT1,   // SHORT lamps, instruction
	parameter logic [3:0] SHORT_PAT2  = ebsi_pkg::ERR_SHORT2,   // SHORT lamps, slot
	parameter logic [3:0] SHORT_PAT3  = ebsi_pkg::ERR_SHORT3,   // SHORT lamps, foreign nmi
	parameter logic [10:0] LONG_TIME  = ebsi_pkg::LONG_MS,      // LONG time in ticks
	parameter logic [10:0] SHORT_TIME = ebsi_pkg::SHORT_MS      // SHORT time in ticks
) (
	input  wire logic                   clk,
	input  wire logic                   rst,
	// start-up strobes from the board processor
	input  wire logic                   mpuInitDone,
	input  wire logic                   firmwareLoaded,
	input  wire logic                   osHandoff,
	input  wire logic                   osPhaseStep,
	input  wire logic                   startupDone,
	input  wire logic                   errorStrobe,
	input  wire logic [2:0]             errorCode,
	input  wire logic                   parityError,
	// network interface status
	input  wire logic                   rxActive,
	input  wire logic                   txActive,
	input  wire logic                   hubLinkUp,
	input  wire logic                   collision,
	input  wire logic                   speed100,
	// register port
	input  wire logic [ebsi_pkg::AW-1:0] regAddr,
	input  wire logic [31:0]            regWdata,
	input  wire logic                   regWrite,
	input  wire logic                   regRead,
	output logic      [31:0]            regRdata,
	output logic                        irq,
	// lamps and frame gate
	output logic      [3:0]             statusLamps,
	output logic                        memoryAlarmLamp,
	output logic                        activityLamp,
	output logic                        linkLamp,
	output logic                        collisionLamp,
	output logic                        fastSpeedLamp,
	output logic                        frameEnable
);
	import ebsi_pkg::*;

	// time base
	logic tick;  // one-cycle pulse each ms

	ebsi_tick_div #(
		.CYCLES (TICK_CYCLES)
	) u_tick (
		.clk  (clk),
		.rst  (rst),
		.tick (tick)
	);

	// start-up sequencer
	ebsi_seq_t    seq_q;      // current start-up step
	ebsi_seq_t    seq_d;
	logic [2:0]   code_q;     // latched error code
	logic [2:0]   code_d;
	logic         doneEv;     // entered completion this cycle
	logic         errEv;      // entered error this cycle

	// each strobe is taken only in the step before its own, so a stray
	// or repeated strobe cannot skip a pattern; errors win from any step
	always_comb begin
		seq_d  = seq_q;
		code_d = code_q;
		doneEv = 1'b0;
		errEv  = 1'b0;
		if (errorStrobe && seq_q != SEQ_ERROR) begin
			seq_d  = SEQ_ERROR;
			code_d = errorCode;
			errEv  = 1'b1;
		end else begin
			case (seq_q)
				SEQ_RESET: if (mpuInitDone) begin
					seq_d = SEQ_MPU;
				end
				SEQ_MPU: if (firmwareLoaded) begin
					seq_d = SEQ_FW;
				end
				SEQ_FW: if (osHandoff) begin
					seq_d = SEQ_OS;
				end
				SEQ_OS: if (osPhaseStep) begin
					seq_d = SEQ_PH1;
				end
				SEQ_PH1: if (osPhaseStep) begin
					seq_d = SEQ_PH2;
				end
				SEQ_PH2: if (osPhaseStep) begin
					seq_d = SEQ_PH3;
				end
				SEQ_PH3: if (osPhaseStep) begin
					seq_d = SEQ_PH4;
				end
				SEQ_PH4: if (startupDone) begin
					seq_d  = SEQ_DONE;
					doneEv = 1'b1;
				end
				SEQ_DONE: begin
					seq_d = SEQ_DONE;
				end
				SEQ_ERROR: begin
					seq_d = SEQ_ERROR;                      // only reset leaves an error
				end
				default: begin
					seq_d = SEQ_RESET;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			seq_q  <= SEQ_RESET;
			code_q <= 3'h0;
		end else begin
			seq_q  <= seq_d;
			code_q <= code_d;
		end
	end

	// blink and error code timers
	logic [TW-1:0] blinkCnt_q;  // ticks in current blink half
	logic [TW-1:0] blinkCnt_d;
	logic          blink_q;     // blink phase, high is lit
	logic          blink_d;
	logic [TW-1:0] errCnt_q;    // ticks in current LONG or SHORT
	logic [TW-1:0] errCnt_d;
	logic          short_q;     // high while SHORT shown
	logic          short_d;
	logic [TW-1:0] errLimit;    // length of the current half

	// error display always restarts with LONG when the error is taken,
	// so the first thing an observer sees is the long half
	always_comb begin
		blinkCnt_d = blinkCnt_q;
		blink_d    = blink_q;
		errCnt_d   = errCnt_q;
		short_d    = short_q;
		errLimit   = short_q ? SHORT_TIME : LONG_TIME;
		if (tick) begin
			if (blinkCnt_q >= BLINK_HALF_MS - TW'(1)) begin
				blinkCnt_d = '0;
				blink_d    = ~blink_q;
			end else begin
				blinkCnt_d = blinkCnt_q + TW'(1);
			end
			if (errCnt_q >= errLimit - TW'(1)) begin
				errCnt_d = '0;
				short_d  = ~short_q;
			end else begin
				errCnt_d = errCnt_q + TW'(1);
			end
		end
		if (errEv) begin
			errCnt_d = '0;
			short_d  = 1'b0;
		end
		if (doneEv) begin
			blinkCnt_d = '0;
			blink_d    = 1'b1;                          // completion starts lit
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			blinkCnt_q <= '0;
			blink_q    <= 1'b0;
			errCnt_q   <= '0;
			short_q    <= 1'b0;
		end else begin
			blinkCnt_q <= blinkCnt_d;
			blink_q    <= blink_d;
			errCnt_q   <= errCnt_d;
			short_q    <= short_d;
		end
	end

	// status lamp pattern
	logic [3:0] lamps_q;   // registered status lamps
	logic [3:0] lamps_d;
	logic [3:0] shortPat;  // SHORT pattern of the latched code

	// unknown codes still run long-then-short; the high lamp plus the low
	// code bits keeps their SHORT apart from LONG and from each other
	always_comb begin
		case (code_q)
			ERR_PARITY:  shortPat = SHORT_PAT0;
			ERR_INSTR:   shortPat = SHORT_PAT1;
			ERR_SLOT:    shortPat = SHORT_PAT2;
			ERR_FOREIGN: shortPat = SHORT_PAT3;
			default:     shortPat = ERR_SHORT_HI | {2'b00, code_q[1:0]};
		endcase
		case (seq_d)
			SEQ_RESET: lamps_d = PAT_RESET;
			SEQ_MPU:   lamps_d = PAT_MPU;
			SEQ_FW:    lamps_d = PAT_FW;
			SEQ_OS:    lamps_d = PAT_OS;
			SEQ_PH1:   lamps_d = PAT_PH1;
			SEQ_PH2:   lamps_d = PAT_PH2;
			SEQ_PH3:   lamps_d = PAT_PH3;
			SEQ_PH4:   lamps_d = PAT_PH4;
			SEQ_DONE:  lamps_d = {3'b000, blink_d};
			SEQ_ERROR: lamps_d = short_d ? shortPat : LONG_PAT;
			default:   lamps_d = PAT_RESET;
		endcase
	end

	// the SHORT pattern uses code_q, so on the error entry cycle the
	// LONG half is shown, which needs no code yet
	always_ff @(posedge clk) begin
		if (rst) begin
			lamps_q <= PAT_RESET;
		end else begin
			lamps_q <= lamps_d;
		end
	end

	// link lamps and frame gate
	logic link_q;    // hub connection seen last cycle
	logic link_d;
	logic fast_q;
	logic fast_d;
	logic gateOk;    // frames allowed this cycle
	logic actLamp;
	logic colLamp;

	// link and speed are plain levels; the fast lamp needs the link too
	always_comb begin
		link_d = hubLinkUp;
		fast_d = hubLinkUp && speed100;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			link_q <= 1'b0;
			fast_q <= 1'b0;
		end else begin
			link_q <= link_d;
			fast_q <= fast_d;
		end
	end

	// gating activity by the link keeps the lamp honest with the frame gate
	assign gateOk = link_q;

	ebsi_lamp_stretch #(
		.HOLD (STRETCH_MS)
	) u_act (
		.clk   (clk),
		.rst   (rst),
		.tick  (tick),
		.cause ((rxActive || txActive) && gateOk),
		.lamp  (actLamp)
	);

	// collisions are often one-cycle events; the stretch makes them visible
	ebsi_lamp_stretch #(
		.HOLD (STRETCH_MS)
	) u_col (
		.clk   (clk),
		.rst   (rst),
		.tick  (tick),
		.cause (collision),
		.lamp  (colLamp)
	);

	// memory alarm lamp
	logic alarm_q;   // latched parity alarm
	logic alarm_d;
	logic alarmClr;  // software clear from the control register

	// a parity error in the clearing cycle keeps the lamp lit
	always_comb begin
		alarm_d = alarm_q;
		if (alarmClr) begin
			alarm_d = 1'b0;
		end
		if (parityError) begin
			alarm_d = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			alarm_q <= 1'b0;
		end else begin
			alarm_q <= alarm_d;
		end
	end

	// registers, events and interrupt
	logic [EV_W-1:0] event_q;  // sticky event bits
	logic [EV_W-1:0] event_d;
	logic [EV_W-1:0] mask_q;   // interrupt enables
	logic [EV_W-1:0] mask_d;
	logic [EV_W-1:0] evSet;    // events raised this cycle
	logic [31:0]     rdata_q;
	logic [31:0]     rdata_d;
	logic            irq_q;
	logic            irq_d;
	logic [31:0]     stateWord;

	assign alarmClr = regWrite && regAddr == REG_CTRL && regWdata[CTRL_ALARM_CLR];

	// read data stand one cycle only; unmapped addresses read zero;
	// a new event in the read-clear cycle survives the clear
	always_comb begin
		evSet             = '0;
		evSet[EV_DONE]    = doneEv;
		evSet[EV_ERROR]   = errEv;
		evSet[EV_PARITY]  = parityError;
		evSet[EV_LINK]    = link_d != link_q;
		evSet[EV_COLL]    = collision;
		stateWord                   = 32'h0000_0000;
		stateWord[ST_LAMPS +: 4]    = lamps_q;
		stateWord[ST_SEQ +: 4]      = seq_q;
		stateWord[ST_CODE +: 3]     = code_q;
		stateWord[ST_ALARM]         = alarm_q;
		stateWord[ST_LINK]          = link_q;
		stateWord[ST_FAST]          = fast_q;
		stateWord[ST_SHORT]         = short_q;
		event_d = event_q;
		mask_d  = mask_q;
		rdata_d = 32'h0000_0000;
		if (regRead) begin
			case (regAddr)
				REG_EVENT: begin
					rdata_d = {{(32-EV_W){1'b0}}, event_q};
					event_d = '0;
				end
				REG_MASK:  rdata_d = {{(32-EV_W){1'b0}}, mask_q};
				REG_STATE: rdata_d = stateWord;
				default:   rdata_d = 32'h0000_0000;
			endcase
		end
		if (regWrite && regAddr == REG_MASK) begin
			mask_d = regWdata[EV_W-1:0];
		end
		event_d = event_d | evSet;
		irq_d   = |(event_d & mask_d);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			event_q <= '0;
			mask_q  <= MASK_RESET;
			rdata_q <= 32'h0000_0000;
			irq_q   <= 1'b0;
		end else begin
			event_q <= event_d;
			mask_q  <= mask_d;
			rdata_q <= rdata_d;
			irq_q   <= irq_d;
		end
	end

	// outputs, all from flip-flops
	assign regRdata        = rdata_q;
	assign irq             = irq_q;
	assign statusLamps     = lamps_q;
	assign memoryAlarmLamp = alarm_q;
	assign activityLamp    = actLamp;
	assign linkLamp        = link_q;
	assign collisionLamp   = colLamp;
	assign fastSpeedLamp   = fast_q;
	assign frameEnable     = link_q;
endmodule

// ===== verilog/ebsi_pkg.sv
// constants shared by the network board indicator logic
// assumes a single 250 MHz clock; all lamp times count in 1 ms ticks
package ebsi_pkg;

	// clock and time base
	localparam int CLK_PERIOD_NS = 4;                           // 250 MHz system clock
	localparam int TICK_TIME_NS  = 1_000_000;                   // lamp time base, 1 ms
	localparam int TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS; // cycles per tick

	// lamp timings in ticks (ms)
	localparam int TW = 11;                                     // tick counter width
	localparam logic [TW-1:0] BLINK_HALF_MS = 11'd500;          // completion blink half period
	localparam logic [TW-1:0] LONG_MS       = 11'd1500;         // error LONG display time
	localparam logic [TW-1:0] SHORT_MS      = 11'd500;          // error SHORT display time
	localparam logic [TW-1:0] STRETCH_MS    = 11'd50;           // least visible flash of a lamp

	// status lamp patterns, bit 0 is lamp 1, a set bit is a lit lamp
	localparam logic [3:0] PAT_RESET = 4'h0;                    // power-on, before any strobe
	localparam logic [3:0] PAT_MPU   = 4'hE;                    // off on on on
	localparam logic [3:0] PAT_FW    = 4'hC;                    // off off on on
	localparam logic [3:0] PAT_OS    = 4'h8;                    // off off off on
	localparam logic [3:0] PAT_PH1   = 4'h7;                    // on on on off
	localparam logic [3:0] PAT_PH2   = 4'h6;                    // off on on off
	localparam logic [3:0] PAT_PH3   = 4'h5;                    // on off on off
	localparam logic [3:0] PAT_PH4   = 4'h4;                    // off off on off

	// error codes on the error input
	localparam logic [2:0] ERR_PARITY  = 3'h0;                  // memory parity alarm
	localparam logic [2:0] ERR_INSTR   = 3'h1;                  // general invalid instruction
	localparam logic [2:0] ERR_SLOT    = 3'h2;                  // invalid slot instruction
	localparam logic [2:0] ERR_FOREIGN = 3'h3;                  // nmi raised by another module

	// default error lamp patterns, one LONG pattern and a SHORT pattern per code
	localparam logic [3:0] ERR_LONG_PAT = 4'hF;
	localparam logic [3:0] ERR_SHORT0   = 4'h1;
	localparam logic [3:0] ERR_SHORT1   = 4'h2;
	localparam logic [3:0] ERR_SHORT2   = 4'h3;
	localparam logic [3:0] ERR_SHORT3   = 4'h4;
	localparam logic [3:0] ERR_SHORT_HI = 4'h8;                 // or-ed onto low code bits

	// register map, byte addresses
	localparam int AW = 8;
	localparam logic [AW-1:0] REG_EVENT = 8'h00;                // sticky events, read clears
	localparam logic [AW-1:0] REG_MASK  = 8'h04;                // interrupt mask, 1 enables
	localparam logic [AW-1:0] REG_STATE = 8'h08;                // lamp and sequencer state
	localparam logic [AW-1:0] REG_CTRL  = 8'h0C;                // write-one actions

	// event bit positions
	localparam int EV_W      = 5;
	localparam int EV_DONE   = 0;
	localparam int EV_ERROR  = 1;
	localparam int EV_PARITY = 2;
	localparam int EV_LINK   = 3;
	localparam int EV_COLL   = 4;
	localparam logic [EV_W-1:0] MASK_RESET = 5'h00;

	// control and state field positions
	localparam int CTRL_ALARM_CLR = 0;
	localparam int ST_LAMPS   = 0;                              // [3:0]
	localparam int ST_SEQ     = 4;                              // [7:4]
	localparam int ST_CODE    = 8;                              // [10:8]
	localparam int ST_ALARM   = 11;
	localparam int ST_LINK    = 12;
	localparam int ST_FAST    = 13;
	localparam int ST_SHORT   = 14;

	// start-up sequencer states
	typedef enum logic [3:0] {
		SEQ_RESET = 4'b0000,
		SEQ_MPU   = 4'b0001,
		SEQ_FW    = 4'b0010,
		SEQ_OS    = 4'b0011,
		SEQ_PH1   = 4'b0100,
		SEQ_PH2   = 4'b0101,
		SEQ_PH3   = 4'b0110,
		SEQ_PH4   = 4'b0111,
		SEQ_DONE  = 4'b1000,
		SEQ_ERROR = 4'b1001
	} ebsi_seq_t;

endpackage

// ===== verilog/ebsi_tick_div.sv
// divides the system clock down to a one-cycle tick enable
// assumes CYCLES is at least 2
`timescale 1ns/1ps
module ebsi_tick_div #(
	parameter int CYCLES = 250_000
) (
	input  wire logic clk,
	input  wire logic rst,
	output logic      tick
);
	localparam int CW = $clog2(CYCLES + 1);

	logic [CW-1:0] cnt_q;   // cycles since last tick
	logic [CW-1:0] cnt_d;
	logic          tick_q;  // registered pulse
	logic          tick_d;

	// wrap at CYCLES-1 and fire the tick on the wrap
	always_comb begin
		cnt_d  = cnt_q + CW'(1);
		tick_d = 1'b0;
		if (cnt_q == CW'(CYCLES - 1)) begin
			cnt_d  = '0;
			tick_d = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_q  <= '0;
			tick_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tick = tick_q;
endmodule

// ===== verilog/ebsi_lamp_stretch.sv
// keeps a lamp lit while its cause holds and for a hold time after it
// assumes tick is a one-cycle enable, hold counted in ticks
`timescale 1ns/1ps
module ebsi_lamp_stretch
	import ebsi_pkg::*;
#(
	parameter logic [ebsi_pkg::TW-1:0] HOLD = ebsi_pkg::STRETCH_MS
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic tick,
	input  wire logic cause,
	output logic      lamp
);
	logic [TW-1:0] hold_q;  // ticks left to stay lit
	logic [TW-1:0] hold_d;
	logic          lamp_q;
	logic          lamp_d;

	// a cause reloads the hold, so a short pulse still gives a visible flash
	always_comb begin
		hold_d = hold_q;
		if (cause) begin
			hold_d = HOLD;
		end else if (tick && hold_q != '0) begin
			hold_d = hold_q - TW'(1);
		end
		lamp_d = cause || (hold_d != '0);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			hold_q <= '0;
			lamp_q <= 1'b0;
		end else begin
			hold_q <= hold_d;
			lamp_q <= lamp_d;
		end
	end

	assign lamp = lamp_q;
endmodule

// ===== tb/ebsi_indicator_asserts.sv
// lamp and status timing checks for the board indicator logic
// assumes single clock domain and synchronous reset of the bound block
`timescale 1ns/1ps
module ebsi_indicator_asserts
	import ebsi_pkg::*;
#(
	parameter int          TICK_CYCLES = 4,     // cycles per lamp tick
	parameter logic [10:0] LONG_TIME   = 11'd6  // LONG display in ticks
) (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       mpuInitDone,
	input wire logic       firmwareLoaded,
	input wire logic       errorStrobe,
	input wire logic       parityError,
	input wire logic       rxActive,
	input wire logic       txActive,
	input wire logic       hubLinkUp,
	input wire logic       collision,
	input wire logic       speed100,
	input wire logic [3:0] statusLamps,
	input wire logic       memoryAlarmLamp,
	input wire logic       activityLamp,
	input wire logic       linkLamp,
	input wire logic       collisionLamp,
	input wire logic       fastSpeedLamp,
	input wire logic       frameEnable
);
	// first LONG may lose up to one tick, the tick phase is free running
	localparam int MINF = (LONG_TIME - 1) * TICK_CYCLES;
	localparam int MAXF = LONG_TIME * TICK_CYCLES;
	logic inErr_q, inErr_d;  // error pattern seen since reset
	logic quiet_q, quiet_d;  // lamps dark ever since reset
	int   runF_q, runF_d;    // cycles the LONG pattern has stood
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// helper state, needed because error SHORT codes can mimic boot patterns
	always_comb begin
		inErr_d = rst ? 1'b0 : inErr_q | (statusLamps == 4'hF);
		quiet_d = rst ? 1'b1 : quiet_q & (statusLamps == PAT_RESET);
		runF_d  = (!rst && statusLamps == 4'hF) ? runF_q + 1 : 0;
	end
	always_ff @(posedge clk) begin
		inErr_q <= inErr_d;
		quiet_q <= quiet_d;
		runF_q  <= runF_d;
	end
	sequence s_new_error;
		errorStrobe && !inErr_q;
	endsequence
	sequence s_long_end;
		$past(statusLamps) == 4'hF && statusLamps != 4'hF;
	endsequence
	a_first_step: assert property (quiet_q && mpuInitDone |=> statusLamps == PAT_MPU)
		else $error("processor step pattern wrong");
	a_reset_hold: assert property (quiet_q && statusLamps == PAT_RESET && !mpuInitDone
		&& !errorStrobe |=> statusLamps == PAT_RESET) else $error("reset pattern left early");
	a_fw_step: assert property (!inErr_q && statusLamps == PAT_MPU && firmwareLoaded
		&& !errorStrobe |=> statusLamps == PAT_FW) else $error("firmware step pattern wrong");
	a_err_long: assert property (s_new_error |=> statusLamps == 4'hF)
		else $error("error did not start with LONG");
	a_long_span: assert property (s_long_end |-> runF_q >= MINF && runF_q <= MAXF)
		else $error("LONG interval out of range");
	a_alarm_set: assert property (parityError |=> memoryAlarmLamp)
		else $error("alarm lamp missed parity error");
	a_activity_on: assert property ((rxActive || txActive) && linkLamp |=> activityLamp)
		else $error("activity lamp dark during traffic");
	a_link_follow: assert property (!$past(rst) |-> linkLamp == $past(hubLinkUp))
		else $error("link lamp not following hub");
	a_coll_on: assert property (collision |=> collisionLamp)
		else $error("collision lamp missed collision");
	a_fast_follow: assert property (!$past(rst)
		|-> fastSpeedLamp == $past(hubLinkUp && speed100)) else $error("fast lamp wrong");
	a_frame_gate: assert property ($rose(activityLamp) |-> $past(linkLamp && frameEnable))
		else $error("activity without link");
endmodule
bind ebsi_indicator ebsi_indicator_asserts #(.TICK_CYCLES(TICK_CYCLES), .LONG_TIME(LONG_TIME)) chk (
	.clk(clk), .rst(rst), .mpuInitDone(mpuInitDone), .firmwareLoaded(firmwareLoaded),
	.errorStrobe(errorStrobe), .parityError(parityError), .rxActive(rxActive),
	.txActive(txActive), .hubLinkUp(hubLinkUp), .collision(collision), .speed100(speed100),
	.statusLamps(statusLamps), .memoryAlarmLamp(memoryAlarmLamp), .activityLamp(activityLamp),
	.linkLamp(linkLamp), .collisionLamp(collisionLamp), .fastSpeedLamp(fastSpeedLamp),
	.frameEnable(frameEnable)
);

// ===== tb/ebsi_hub_model.sv
// hub at the far end of the board's network cable
// assumes bench requests change just after rising clk edges
`timescale 1ns/1ps
module ebsi_hub_model (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       plugIn,    // cable in and hub powered
	input  wire logic       fastMode,  // hub offers the fast rate
	input  wire logic [7:0] upDelay,   // negotiation time in cycles
	input  wire logic       sendFrame, // start one received frame
	input  wire logic       txActive,  // board is transmitting
	output logic            hubLinkUp,
	output logic            speed100,
	output logic            rxActive,
	output logic            collision
);
	logic [7:0] wait_q  = 8'h00; // negotiation cycles so far
	logic [3:0] frame_q = 4'h0;  // cycles left of the frame on the wire
	logic       up_q    = 1'b0;  // link reported
	logic       coll_q  = 1'b0;  // both ends talking at once
	// link comes up only after negotiation; a pulled cable aborts any frame
	always @(posedge clk) begin
		if (rst || !plugIn) begin
			wait_q  <= 8'h00;
			up_q    <= 1'b0;
			frame_q <= 4'h0;
		end else if (wait_q != upDelay) begin
			wait_q <= wait_q + 8'h01;
		end else begin
			up_q <= 1'b1;
			if (sendFrame && frame_q == 4'h0)
				frame_q <= 4'h8;
			else if (frame_q != 4'h0)
				frame_q <= frame_q - 4'h1;
		end
		coll_q <= (frame_q != 4'h0) && txActive;
	end
	// speed strap is shown even without link, the board must gate it
	assign speed100  = fastMode;
	assign hubLinkUp = up_q;
	assign rxActive  = frame_q != 4'h0;
	assign collision = coll_q;
endmodule

// ===== tb/test_ebsi_indicator.sv
// self-checking bench for the board indicator logic
// assumes the hub model and bound checker; one lamp tick is 4 cycles here
`timescale 1ns/1ps
module test_ebsi_indicator;
	import ebsi_pkg::*;
	localparam int          TC = 4;      // cycles per tick, shortened
	localparam logic [10:0] LT = 11'd6;  // LONG ticks
	localparam logic [10:0] ST = 11'd2;  // SHORT ticks
	logic clk, rst, txActive, hubLinkUp, speed100, rxActive, collision, irq;
	logic plugIn, fastMode, sendFrame, regWrite, regRead;
	logic [6:0]  stb;  // mpu, fw, os, phase, done, parity, error strobes
	logic [2:0]  errorCode;
	logic [7:0]  upDelay, regAddr;
	logic [31:0] regWdata, regRdata;
	logic [3:0]  statusLamps;
	logic memoryAlarmLamp, activityLamp, linkLamp, collisionLamp, fastSpeedLamp, frameEnable;
	int nErrors = 0;
	int samplesChecked = 0;
	int steps [8] = '{0, 1, 2, 3, 3, 3, 3, 4};
	logic [3:0] pats [8] = '{PAT_MPU, PAT_FW, PAT_OS, PAT_PH1, PAT_PH2, PAT_PH3, PAT_PH4, 4'h1};
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	ebsi_indicator #(.TICK_CYCLES(TC), .LONG_TIME(LT), .SHORT_TIME(ST)) uut (
		.clk(clk), .rst(rst), .mpuInitDone(stb[0]), .firmwareLoaded(stb[1]),
		.osHandoff(stb[2]), .osPhaseStep(stb[3]), .startupDone(stb[4]), .parityError(stb[5]),
		.errorStrobe(stb[6]), .errorCode(errorCode), .rxActive(rxActive), .txActive(txActive),
		.hubLinkUp(hubLinkUp), .collision(collision), .speed100(speed100), .regAddr(regAddr),
		.regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
		.irq(irq), .statusLamps(statusLamps), .memoryAlarmLamp(memoryAlarmLamp),
		.activityLamp(activityLamp), .linkLamp(linkLamp), .collisionLamp(collisionLamp),
		.fastSpeedLamp(fastSpeedLamp), .frameEnable(frameEnable));
	ebsi_hub_model hub (.clk(clk), .rst(rst), .plugIn(plugIn), .fastMode(fastMode),
		.upDelay(upDelay), .sendFrame(sendFrame), .txActive(txActive), .hubLinkUp(hubLinkUp),
		.speed100(speed100), .rxActive(rxActive), .collision(collision));
	// verdict and end of run, also reached from a spent wait
	task automatic endOfTest();
		$display("checks %0d, mismatches %0d", samplesChecked, nErrors);
		if (nErrors == 0 && samplesChecked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samplesChecked++;
		if (got !== exp) begin
			nErrors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// wait n edges, then let their updates settle
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic pulse(input int i);
		@(posedge clk);
		stb[i] <= 1'b1;
		@(posedge clk);
		stb[i] <= 1'b0;
		#1;
	endtask
	task automatic doRst();
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		cyc(1);
	endtask
	task automatic regWr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		regAddr  <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
		#1;
	endtask
	// read data stand only in the cycle after the read strobe
	task automatic regRd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		#1;
		check(regRdata, exp);
	endtask
	task automatic waitLink();
		int w;
		for (w = 0; w < 40 && linkLamp !== 1'b1; w++)
			cyc(1);
		if (w == 40) begin
			nErrors++;
			$display("mismatch at %0t: link lamp never lit", $time);
			endOfTest();
		end
	endtask
	// expected SHORT lamps of an error code, unlisted codes get the high lamp
	function automatic logic [3:0] shortPat(input logic [2:0] c);
		case (c)
			3'h0: return ERR_SHORT0;
			3'h1: return ERR_SHORT1;
			3'h2: return ERR_SHORT2;
			3'h3: return ERR_SHORT3;
			default: return ERR_SHORT_HI | {2'b00, c[1:0]};
		endcase
	endfunction
	initial begin
		{stb, errorCode, txActive, plugIn, fastMode, sendFrame, upDelay} = '0;
		{regAddr, regWdata, regWrite, regRead} = '0;
		void'($urandom(32'he9ea_a176));
		doRst();
		pulse(1);
		check(statusLamps, PAT_RESET);
		regWr(REG_MASK, 32'h0000_0001);
		// boot walk with random idle gaps between strobes
		for (int i = 0; i < 8; i++) begin
			cyc($urandom_range(0, 3));
			pulse(steps[i]);
			check(statusLamps, pats[i]);
		end
		check(irq, 1'b1);
		regRd(REG_EVENT, 32'h0000_0001);
		check(irq, 1'b0);
		cyc(1980);
		check(statusLamps, 4'h1);
		cyc(30);
		check(statusLamps, 4'h0);
		cyc(2000);
		check(statusLamps, 4'h1);
		// link up at both rates, traffic, collision, then cable pulled
		for (int k = 0; k < 4; k++) begin
			@(posedge clk);
			fastMode <= k[0];
			upDelay  <= 8'($urandom_range(1, 20));
			plugIn   <= 1'b1;
			txActive <= 1'b0;
			waitLink();
			check(fastSpeedLamp, k[0]);
			check(frameEnable, 1'b1);
			@(posedge clk);
			sendFrame <= 1'b1;
			txActive  <= k[1];
			cyc(4);
			check(activityLamp, 1'b1);
			check(collisionLamp, k[1]);
			sendFrame <= 1'b0;
			plugIn    <= 1'b0;
			txActive  <= 1'b1;
			cyc(225);
			check(linkLamp, 1'b0);
			check(fastSpeedLamp, 1'b0);
			check({frameEnable, activityLamp}, 2'b00);
			txActive <= 1'b0;
		end
		regRd(8'h10, 32'h0000_0000);
		regWr(REG_EVENT, 32'hFFFF_FFFF);
		regRd(REG_EVENT, 32'h0000_0018);
		regWr(REG_MASK, 32'h0000_0004);
		pulse(5);
		check({irq, memoryAlarmLamp}, 2'b11);
		regWr(REG_MASK, 32'h0000_0000);
		cyc(1);
		check(irq, 1'b0);
		regRd(REG_EVENT, 32'h0000_0004);
		regWr(REG_CTRL, 32'h0000_0001);
		check(memoryAlarmLamp, 1'b0);
		// every error code, the first straight out of completion
		for (int c = 0; c < 8; c++) begin
			if (c != 0) begin
				doRst();
				pulse(0);
			end
			cyc($urandom_range(0, 5));
			errorCode <= 3'(c);
			pulse(6);
			check(statusLamps, 4'hF);
			errorCode <= ~3'(c);
			pulse(6);
			cyc(23);
			check(statusLamps, shortPat(3'(c)));
			cyc(9);
			check(statusLamps, 4'hF);
		end
		endOfTest();
	end
endmodule
